//--- logic/tps_defines.svh
// Register map, field positions and reset values of the pulse shaper
`ifndef TPS_DEFINES_SVH
`define TPS_DEFINES_SVH
`define TPS_OFF_WAVE_CTRL 8'h00
`define TPS_OFF_WAVE_VALUE 8'h04
`define TPS_OFF_SHAPE 8'h08
`define TPS_OFF_GAIN 8'h0c
`define TPS_OFF_TXCFG 8'h10
`define TPS_OFF_IRQ_STAT 8'h14
`define TPS_OFF_IRQ_MASK 8'h18
`define TPS_OFF_IRQ_EDGE 8'h1c
`define TPS_OFF_LINE_COND 8'h20
`define TPS_OFF_TMF_SEL 8'h24
`define TPS_OFF_ROM_LOAD 8'h28
`define TPS_BIT_DIR 5
`define TPS_BIT_TRIG 6
`define TPS_BIT_SIGN 6
`define TPS_BIT_USER 3
`define TPS_BIT_SINGLE 3
`define TPS_BIT_FLOAT 4
`define TPS_BIT_OE 6
`define TPS_BIT_OC 4
`define TPS_BIT_OVF 7
`define TPS_PHASES 5'h14
`define TPS_LAST_PHASE 5'h13
`define TPS_TEMPLATES 4'h8
`define TPS_GAIN_RST 6'h36
`define TPS_AMP_MAX 9'sh03f
`define TPS_RESP_OKAY 2'h0
`define TPS_RESP_SLVERR 2'h2
`endif

//--- logic/tps_pkg.sv
// Types shared by the pulse shaper design
package tps_pkg;
    typedef logic [6:0] tps_sample_t;
    typedef logic signed [8:0] tps_sum_t;
    typedef logic signed [14:0] tps_code_t;
endpackage

//--- logic/tps_shaper.sv
// Transmit pulse shaper, waveform memory and line driver control, one channel
`timescale 1ns/1ps
`include "tps_defines.svh"
// Notes on behaviour
// - Shape select MSB set: pulse comes from the user waveform memory.
// - Pulse is 20 phases over 1.25 UI, addressed by phase_index bits 4:0.
// - Phase amplitude is 7-bit sign-magnitude, +63 to -63, value bits 6:0.
// - Eight ROM templates; software may copy one into memory and edit it.
// - Gain field scales the whole waveform up or down per step.
// - Fetch: ctrl with dir 1, trigger 1 puts sample in value register.
// - Summed overlapping pulse beyond limit sets overflow flag; enable gates irq.
// - Shortest T1 and J1 templates are identical, 17H,27H..4AH..00H,00H.
// - Longest T1 template is 20H,3FH, 5FH at phase 10, 00H at 20.
// - Global pin low or channel enable bit clear floats the line driver.
// - Float acts at once on both outputs; internal logic keeps running.
// - Over-current: current limit if float select 0, else float outputs.
// - Live over-current sets its flag on rising or any edge, as selected.
// - Set over-current flag raises irq unless its mask bit blocks it.
// - Over-current is selectable onto the multifunction pin.
// - Config bit 3: differential drives both outputs, single-ended only positive.
// - Each gain step changes amplitude by about 2% T1, 3% E1.
module tps_shaper import tps_pkg::*; #(
    parameter int ADDR_W = 8
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic ui_strobe_in,
    input wire logic phase_tick_in,
    input wire logic mark_in,
    input wire logic polarity_in,
    input wire logic output_enable_in,
    input wire logic tx_overcurrent_in,
    output logic signed [14:0] tx_line_positive_out,
    output logic signed [14:0] tx_line_negative_out,
    output logic tx_line_positive_oe_n_out,
    output logic tx_line_negative_oe_n_out,
    output logic current_limit_out,
    output logic tx_multifunction_pin_out,
    output logic irq_out
);
    // Preset templates, index = shape_select[2:0]
    localparam tps_sample_t ROM [`TPS_TEMPLATES][`TPS_PHASES] = '{
        '{7'h00, 7'h00, 7'h00, 7'h0c, 7'h30, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00,
          7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00},
        '{7'h00, 7'h00, 7'h00, 7'h0f, 7'h3c, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00,
          7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00},
        '{7'h17, 7'h27, 7'h27, 7'h26, 7'h25, 7'h25, 7'h25, 7'h24, 7'h23, 7'h4a,
          7'h4a, 7'h49, 7'h47, 7'h45, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00, 7'h00},
        '{7'h1b, 7'h2e, 7'h2c, 7'h2a, 7'h29, 7'h28, 7'h27, 7'h26, 7'h25, 7'h50,
          7'h4f, 7'h4d, 7'h4a, 7'h48, 7'h46, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00},
        '{7'h1f, 7'h34, 7'h2f, 7'h2c, 7'h2b, 7'h2a, 7'h29, 7'h28, 7'h25, 7'h57,
          7'h53, 7'h50, 7'h4b, 7'h48, 7'h46, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00},
        '{7'h20, 7'h3b, 7'h35, 7'h2f, 7'h2e, 7'h2d, 7'h2c, 7'h2a, 7'h28, 7'h58,
          7'h58, 7'h53, 7'h4c, 7'h48, 7'h46, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00},
        '{7'h20, 7'h3f, 7'h38, 7'h33, 7'h2f, 7'h2e, 7'h2d, 7'h2c, 7'h29, 7'h5f,
          7'h5e, 7'h57, 7'h4f, 7'h49, 7'h47, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00},
        '{7'h17, 7'h27, 7'h27, 7'h26, 7'h25, 7'h25, 7'h25, 7'h24, 7'h23, 7'h4a,
          7'h4a, 7'h49, 7'h47, 7'h45, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00, 7'h00}
    };

    tps_sample_t ram [`TPS_PHASES];
    tps_sample_t next_ram [`TPS_PHASES];
    logic [5:0] wave_ctrl, next_wave_ctrl;
    tps_sample_t wave_value, next_wave_value;
    logic [3:0] shape_select, next_shape_select;
    logic [5:0] amplitude_gain, next_amplitude_gain;
    logic cfg_oe, next_cfg_oe, cfg_float, next_cfg_float, cfg_single, next_cfg_single;
    logic ovf_flag, next_ovf_flag, oc_flag, next_oc_flag;
    logic ovf_enable, next_ovf_enable, oc_mask, next_oc_mask, oc_edge_any, next_oc_edge_any;
    logic oc_live, next_oc_live, oc_prev, next_oc_prev, tmf_sel, next_tmf_sel;
    logic bvalid, next_bvalid, rvalid, next_rvalid;
    logic [1:0] bresp, next_bresp, rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic [4:0] slot_cnt [2];
    logic [4:0] next_slot_cnt [2];
    logic [1:0] slot_act, next_slot_act, slot_neg, next_slot_neg;
    logic slot_ptr, next_slot_ptr;
    tps_code_t code_pos, next_code_pos, code_neg, next_code_neg;
    logic tmf, next_tmf;
    logic wr_fire, rd_fire, wr_en, overflow;
    logic [7:0] wbyte;
    logic [4:0] widx;
    tps_sum_t sum, clamped;
    tps_sample_t smp;

    // Unmapped offsets answer with an error response
    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        case (a[7:0])
            `TPS_OFF_WAVE_CTRL, `TPS_OFF_WAVE_VALUE, `TPS_OFF_SHAPE, `TPS_OFF_GAIN,
            `TPS_OFF_TXCFG, `TPS_OFF_IRQ_STAT, `TPS_OFF_IRQ_MASK, `TPS_OFF_IRQ_EDGE,
            `TPS_OFF_LINE_COND, `TPS_OFF_TMF_SEL, `TPS_OFF_ROM_LOAD: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    // Phase sample from user memory or a preset template
    function automatic tps_sample_t sample_at(input logic [4:0] ph);
        if (shape_select[`TPS_BIT_USER]) begin
            sample_at = ram[ph];
        end else begin
            sample_at = ROM[shape_select[2:0]][ph];
        end
    endfunction

    // Write waits for address and data together; one answer outstanding at a time
    assign wr_fire = s_axi_awvalid_in && s_axi_wvalid_in && !bvalid;
    assign rd_fire = s_axi_arvalid_in && !rvalid;
    assign wr_en = wr_fire && s_axi_wstrb_in[0] && mapped(s_axi_awaddr_in);
    assign wbyte = s_axi_wdata_in[7:0];
    assign widx = wbyte[4:0];
    assign s_axi_awready_out = wr_fire;
    assign s_axi_wready_out = wr_fire;
    assign s_axi_arready_out = !rvalid;

    // Register file, memory access and flags
    always_comb begin
        next_ram = ram;
        next_wave_ctrl = wave_ctrl;
        next_wave_value = wave_value;
        next_shape_select = shape_select;
        next_amplitude_gain = amplitude_gain;
        next_cfg_oe = cfg_oe;
        next_cfg_float = cfg_float;
        next_cfg_single = cfg_single;
        next_ovf_flag = ovf_flag;
        next_oc_flag = oc_flag;
        next_ovf_enable = ovf_enable;
        next_oc_mask = oc_mask;
        next_oc_edge_any = oc_edge_any;
        next_tmf_sel = tmf_sel;
        next_oc_live = tx_overcurrent_in;
        next_oc_prev = oc_live;
        if (wr_en) begin
            case (s_axi_awaddr_in[7:0])
                `TPS_OFF_WAVE_CTRL: begin
                    next_wave_ctrl = wbyte[5:0];
                    // Done in the write cycle, so the next access sees it
                    if (wbyte[`TPS_BIT_TRIG] && widx < `TPS_PHASES) begin
                        if (wbyte[`TPS_BIT_DIR]) begin
                            next_wave_value = ram[widx];
                        end else begin
                            next_ram[widx] = wave_value;
                        end
                    end
                end
                `TPS_OFF_WAVE_VALUE: next_wave_value = wbyte[6:0];
                `TPS_OFF_SHAPE: next_shape_select = wbyte[3:0];
                `TPS_OFF_GAIN: next_amplitude_gain = wbyte[5:0];
                `TPS_OFF_TXCFG: begin
                    next_cfg_oe = wbyte[`TPS_BIT_OE];
                    next_cfg_float = wbyte[`TPS_BIT_FLOAT];
                    next_cfg_single = wbyte[`TPS_BIT_SINGLE];
                end
                `TPS_OFF_IRQ_STAT: begin
                    if (wbyte[`TPS_BIT_OVF]) next_ovf_flag = 1'b0;
                    if (wbyte[`TPS_BIT_OC]) next_oc_flag = 1'b0;
                end
                `TPS_OFF_IRQ_MASK: begin
                    next_ovf_enable = wbyte[`TPS_BIT_OVF];
                    next_oc_mask = wbyte[`TPS_BIT_OC];
                end
                `TPS_OFF_IRQ_EDGE: next_oc_edge_any = wbyte[`TPS_BIT_OC];
                `TPS_OFF_TMF_SEL: next_tmf_sel = wbyte[0];
                `TPS_OFF_ROM_LOAD: begin
                    for (int i = 0; i < `TPS_PHASES; i++) begin
                        next_ram[i] = ROM[wbyte[2:0]][i];
                    end
                end
                default: ;
            endcase
        end
        // Sets come after clears so a same-cycle event is kept
        if (oc_live != oc_prev && (oc_live || oc_edge_any)) next_oc_flag = 1'b1;
        if (overflow) next_ovf_flag = 1'b1;
    end

    // Bus answers
    always_comb begin
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        if (wr_fire) begin
            next_bvalid = 1'b1;
            next_bresp = mapped(s_axi_awaddr_in) ? `TPS_RESP_OKAY : `TPS_RESP_SLVERR;
        end else if (s_axi_bready_in) begin
            next_bvalid = 1'b0;
        end
        if (rd_fire) begin
            next_rvalid = 1'b1;
            next_rresp = mapped(s_axi_araddr_in) ? `TPS_RESP_OKAY : `TPS_RESP_SLVERR;
            next_rdata = '0;
            case (s_axi_araddr_in[7:0])
                `TPS_OFF_WAVE_CTRL: next_rdata[5:0] = wave_ctrl;
                `TPS_OFF_WAVE_VALUE: next_rdata[6:0] = wave_value;
                `TPS_OFF_SHAPE: next_rdata[3:0] = shape_select;
                `TPS_OFF_GAIN: next_rdata[5:0] = amplitude_gain;
                `TPS_OFF_TXCFG: begin
                    next_rdata[`TPS_BIT_OE] = cfg_oe;
                    next_rdata[`TPS_BIT_FLOAT] = cfg_float;
                    next_rdata[`TPS_BIT_SINGLE] = cfg_single;
                end
                `TPS_OFF_IRQ_STAT: begin
                    next_rdata[`TPS_BIT_OVF] = ovf_flag;
                    next_rdata[`TPS_BIT_OC] = oc_flag;
                end
                `TPS_OFF_IRQ_MASK: begin
                    next_rdata[`TPS_BIT_OVF] = ovf_enable;
                    next_rdata[`TPS_BIT_OC] = oc_mask;
                end
                `TPS_OFF_IRQ_EDGE: next_rdata[`TPS_BIT_OC] = oc_edge_any;
                `TPS_OFF_LINE_COND: next_rdata[`TPS_BIT_OC] = oc_live;
                `TPS_OFF_TMF_SEL: next_rdata[0] = tmf_sel;
                default: ;
            endcase
        end else if (s_axi_rready_in) begin
            next_rvalid = 1'b0;
        end
    end

    // Two pulse slots, so a 1.25 UI pulse may overlap the next one
    always_comb begin
        next_slot_cnt = slot_cnt;
        next_slot_act = slot_act;
        next_slot_neg = slot_neg;
        next_slot_ptr = slot_ptr;
        sum = '0;
        smp = '0;
        for (int s = 0; s < 2; s++) begin
            if (slot_act[s]) begin
                smp = sample_at(slot_cnt[s]);
                if (smp[`TPS_BIT_SIGN] ^ slot_neg[s]) begin
                    sum = sum - tps_sum_t'({3'h0, smp[5:0]});
                end else begin
                    sum = sum + tps_sum_t'({3'h0, smp[5:0]});
                end
                if (phase_tick_in) begin
                    if (slot_cnt[s] == `TPS_LAST_PHASE) begin
                        next_slot_act[s] = 1'b0;
                    end else begin
                        next_slot_cnt[s] = slot_cnt[s] + 5'h01;
                    end
                end
            end
        end
        if (ui_strobe_in && mark_in) begin
            next_slot_act[slot_ptr] = 1'b1;
            next_slot_cnt[slot_ptr] = '0;
            next_slot_neg[slot_ptr] = polarity_in;
            next_slot_ptr = !slot_ptr;
        end
        // Overflow saturates rather than wrapping the drive code
        overflow = (sum > `TPS_AMP_MAX) || (sum < -`TPS_AMP_MAX);
        clamped = (sum > `TPS_AMP_MAX) ? `TPS_AMP_MAX : (sum < -`TPS_AMP_MAX) ? -`TPS_AMP_MAX : sum;
        // Gain multiplies the code; one step is about 1/54 of nominal in T1
        next_code_pos = tps_code_t'(clamped * $signed({1'b0, amplitude_gain}));
        next_code_neg = cfg_single ? '0 : -next_code_pos;
        next_tmf = tmf_sel ? oc_live : ovf_flag;
    end

    // State registers
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < `TPS_PHASES; i++) ram[i] <= '0;
            wave_ctrl <= '0;
            wave_value <= '0;
            shape_select <= '0;
            amplitude_gain <= `TPS_GAIN_RST;
            cfg_oe <= 1'b1;
            cfg_float <= 1'b0;
            cfg_single <= 1'b0;
            ovf_flag <= 1'b0;
            oc_flag <= 1'b0;
            ovf_enable <= 1'b0;
            oc_mask <= 1'b0;
            oc_edge_any <= 1'b0;
            oc_live <= 1'b0;
            oc_prev <= 1'b0;
            tmf_sel <= 1'b0;
            bvalid <= 1'b0;
            bresp <= '0;
            rvalid <= 1'b0;
            rresp <= '0;
            rdata <= '0;
            slot_cnt <= '{default: '0};
            slot_act <= '0;
            slot_neg <= '0;
            slot_ptr <= 1'b0;
            code_pos <= '0;
            code_neg <= '0;
            tmf <= 1'b0;
        end else begin
            ram <= next_ram;
            wave_ctrl <= next_wave_ctrl;
            wave_value <= next_wave_value;
            shape_select <= next_shape_select;
            amplitude_gain <= next_amplitude_gain;
            cfg_oe <= next_cfg_oe;
            cfg_float <= next_cfg_float;
            cfg_single <= next_cfg_single;
            ovf_flag <= next_ovf_flag;
            oc_flag <= next_oc_flag;
            ovf_enable <= next_ovf_enable;
            oc_mask <= next_oc_mask;
            oc_edge_any <= next_oc_edge_any;
            oc_live <= next_oc_live;
            oc_prev <= next_oc_prev;
            tmf_sel <= next_tmf_sel;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
            slot_cnt <= next_slot_cnt;
            slot_act <= next_slot_act;
            slot_neg <= next_slot_neg;
            slot_ptr <= next_slot_ptr;
            code_pos <= next_code_pos;
            code_neg <= next_code_neg;
            tmf <= next_tmf;
        end
    end

    // Pin and enable bit float the driver combinationally; over-current float waits one clock edge for oc_live
    assign tx_line_positive_oe_n_out = !output_enable_in || !cfg_oe || (oc_live && cfg_float);
    assign tx_line_negative_oe_n_out = tx_line_positive_oe_n_out;
    assign current_limit_out = oc_live && !cfg_float;
    assign irq_out = (ovf_flag && ovf_enable) || (oc_flag && !oc_mask);
    assign tx_line_positive_out = code_pos;
    assign tx_line_negative_out = code_neg;
    assign tx_multifunction_pin_out = tmf;
    assign s_axi_bvalid_out = bvalid;
    assign s_axi_bresp_out = bresp;
    assign s_axi_rvalid_out = rvalid;
    assign s_axi_rresp_out = rresp;
    assign s_axi_rdata_out = rdata;

    // Checks on the design's own registers and outputs
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_ctrl_cmd(d);
        wr_en && s_axi_awaddr_in[7:0] == `TPS_OFF_WAVE_CTRL && wbyte[`TPS_BIT_TRIG]
            && wbyte[`TPS_BIT_DIR] == d && widx < `TPS_PHASES;
    endsequence
    property p_fetch;
        logic [4:0] ix;
        (s_ctrl_cmd(1'b1), ix = widx) |=> wave_value == ram[ix];
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch did not load sample");
    property p_store;
        logic [4:0] ix;
        logic [6:0] v;
        (s_ctrl_cmd(1'b0), ix = widx, v = wave_value) |=> ram[ix] == v;
    endproperty
    a_store: assert property (p_store) else $error("store did not write memory");
    property p_float;
        (!output_enable_in || !cfg_oe) |-> tx_line_positive_oe_n_out && tx_line_negative_oe_n_out;
    endproperty
    a_float: assert property (p_float) else $error("driver not floated");
    property p_oc_drive;
        oc_live |-> (cfg_float ? tx_line_positive_oe_n_out : current_limit_out);
    endproperty
    a_oc_drive: assert property (p_oc_drive) else $error("over-current action wrong");
    property p_oc_rise;
        !oc_live ##1 oc_live |=> oc_flag;
    endproperty
    a_oc_rise: assert property (p_oc_rise) else $error("over-current flag not set");
    property p_irq;
        irq_out == ((ovf_flag && ovf_enable) || (oc_flag && !oc_mask));
    endproperty
    a_irq: assert property (p_irq) else $error("irq does not follow flags");
    property p_ovf;
        overflow |=> ovf_flag;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag not set");
    property p_sticky;
        oc_flag && !(wr_en && s_axi_awaddr_in[7:0] == `TPS_OFF_IRQ_STAT) |=> oc_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without clear");
    property p_single;
        cfg_single [*2] |-> tx_line_negative_out == '0;
    endproperty
    a_single: assert property (p_single) else $error("negative output active");
endmodule

//--- tb/tps_line_model.sv
// Far-side model: driver current comparator and the line seen by the shaper
`timescale 1ns/1ps
module tps_line_model #(
    parameter int DETECT_DELAY = 2
) (
    input wire logic clk_in,
    input wire logic short_in,
    input wire logic signed [14:0] drive_pos_in,
    input wire logic signed [14:0] drive_neg_in,
    input wire logic pos_oe_n_in,
    input wire logic neg_oe_n_in,
    input wire logic limit_in,
    output logic overcurrent_out,
    output logic signed [14:0] line_pos_out,
    output logic signed [14:0] line_neg_out
);
    logic [DETECT_DELAY-1:0] seen = '0;
    logic flip = 1'b0;
    // Comparator is slow, so a short shows only a few cycles later
    always @(posedge clk_in) begin
        seen <= {seen[DETECT_DELAY-2:0], short_in};
        flip <= ~flip;
    end
    assign overcurrent_out = seen[DETECT_DELAY-1];
    // Floating pins toggle so a stale code is never mistaken for a level
    assign line_pos_out = pos_oe_n_in ? {15{flip}} : (limit_in ? drive_pos_in >>> 1 : drive_pos_in);
    assign line_neg_out = neg_oe_n_in ? {15{~flip}} : (limit_in ? drive_neg_in >>> 1 : drive_neg_in);
endmodule

//--- tb/test_tps_shaper.sv
// Bench for the pulse shaper: registers, waveform memory, line and over-current
`timescale 1ns/1ps
`include "tps_defines.svh"
module test_tps_shaper;
    logic clk_in = 0, nrst_in = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic awready, wready, bvalid, arready, rvalid, oc, oep, oen, lim, tmf, irq;
    logic [1:0] bresp, rresp;
    logic ui = 0, tick = 0, mark = 0, pol = 0, oe = 1, short = 0;
    logic [3:0] wstrb = 4'hf;
    logic signed [14:0] lp, ln, vp, vn;
    logic [15:0] rom_tab [11] = '{16'h2017, 16'h24ca, 16'h2980, 16'h7017, 16'h74ca, 16'h7900,
                                  16'h6020, 16'h60bf, 16'h64df, 16'h6980, 16'h0230};
    int n_fail = 0, n_checks = 0, cyc = 0;

    tps_shaper i_tps_shaper (.clk_in(clk_in), .nrst_in(nrst_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .ui_strobe_in(ui), .phase_tick_in(tick), .mark_in(mark), .polarity_in(pol), .output_enable_in(oe),
        .tx_overcurrent_in(oc), .tx_line_positive_out(lp), .tx_line_negative_out(ln),
        .tx_line_positive_oe_n_out(oep), .tx_line_negative_oe_n_out(oen), .current_limit_out(lim),
        .tx_multifunction_pin_out(tmf), .irq_out(irq));
    tps_line_model i_tps_line_model (.clk_in(clk_in), .short_in(short), .drive_pos_in(lp), .drive_neg_in(ln),
        .pos_oe_n_in(oep), .neg_oe_n_in(oen), .limit_in(lim), .overcurrent_out(oc),
        .line_pos_out(vp), .line_neg_out(vn));

    // Free-running 50 MHz clock
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail++;
            conclude();
        end
    end

    task conclude;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s exp %h got %h", nm, e, g);
        end
    endtask
    task chk_code(input string nm, input logic signed [14:0] e, input logic signed [14:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s exp %0d got %0d", nm, e, g);
        end
    endtask
    // Address and data offered together; ready is judged mid-cycle when settled
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `TPS_RESP_OKAY);
        @(posedge clk_in);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        do @(negedge clk_in); while (!(awready && wready));
        @(posedge clk_in);
        awvalid <= 0; wvalid <= 0;
        do @(negedge clk_in); while (!bvalid);
        chk($sformatf("bresp %h", a), {30'h0, er}, {30'h0, bresp});
        @(posedge clk_in);
        bready <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = `TPS_RESP_OKAY);
        @(posedge clk_in);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(negedge clk_in); while (!arready);
        @(posedge clk_in);
        arvalid <= 0;
        do @(negedge clk_in); while (!rvalid);
        chk($sformatf("rdata %h", a), e, rdata);
        chk($sformatf("rresp %h", a), {30'h0, er}, {30'h0, rresp});
        @(posedge clk_in);
        rready <= 0;
    endtask
    task store(input logic [4:0] p, input logic [6:0] v);
        wr(`TPS_OFF_WAVE_VALUE, {25'h0, v});
        wr(`TPS_OFF_WAVE_CTRL, {25'h0, 2'b10, p});
    endtask
    task fetch(input logic [4:0] p, input logic [6:0] e);
        wr(`TPS_OFF_WAVE_CTRL, {25'h0, 2'b11, p});
        rd(`TPS_OFF_WAVE_VALUE, {25'h0, e});
    endtask
    // Lets the registered line codes catch up before looking at them
    task settle;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
    endtask
    task pulse;
        @(posedge clk_in);
        ui <= 1; mark <= 1;
        @(posedge clk_in);
        ui <= 0; mark <= 0;
        settle();
    endtask
    task ticks(input int n);
        repeat (n) begin
            @(posedge clk_in);
            tick <= 1;
            @(posedge clk_in);
            tick <= 0;
        end
        settle();
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge clk_in);
        nrst_in <= 1;
        rd(`TPS_OFF_GAIN, 32'h36);
        rd(`TPS_OFF_TXCFG, 32'h40);
        rd(8'h3c, 32'h0, `TPS_RESP_SLVERR);
        wr(8'h3c, 32'h5, `TPS_RESP_SLVERR);
        // Low byte strobe off: answered OKAY, nothing stored
        wstrb <= 4'he;
        wr(`TPS_OFF_SHAPE, 32'h5);
        wstrb <= 4'hf;
        rd(`TPS_OFF_SHAPE, 32'h0);
        store(5'h03, 7'h45);
        wr(`TPS_OFF_WAVE_VALUE, 32'h0);
        rd(`TPS_OFF_WAVE_CTRL, 32'h03);
        fetch(5'h03, 7'h45);
        rd(`TPS_OFF_WAVE_CTRL, 32'h23);
        // Each row: template, phase, expected sample after a ROM copy
        for (int i = 0; i < 11; i++) begin
            wr(`TPS_OFF_ROM_LOAD, {28'h0, rom_tab[i][15:12]});
            fetch(rom_tab[i][11:7], rom_tab[i][6:0]);
        end
        store(5'h00, 7'h10);
        store(5'h13, 7'h05);
        pulse();
        chk_code("preset", 15'sd0, lp);
        ticks(20);
        wr(`TPS_OFF_SHAPE, 32'h8);
        pulse();
        chk_code("user pos", 15'sd864, lp);
        chk_code("user neg", -15'sd864, ln);
        chk_code("line pos", 15'sd864, vp);
        wr(`TPS_OFF_GAIN, 32'h37);
        settle();
        chk_code("gain step", 15'sd880, lp);
        wr(`TPS_OFF_TXCFG, 32'h48);
        settle();
        chk_code("single neg", 15'sd0, ln);
        wr(`TPS_OFF_TXCFG, 32'h40);
        @(posedge clk_in);
        oe <= 0;
        @(negedge clk_in);
        chk("oe pin", 32'h3, {30'h0, oep, oen});
        chk_code("runs floated", 15'sd880, lp);
        @(posedge clk_in);
        oe <= 1;
        ticks(19);
        chk_code("phase 19", 15'sd275, lp);
        ticks(1);
        chk_code("pulse end", 15'sd0, lp);
        // Two overlapping pulses whose sum passes the limit
        store(5'h00, 7'h30);
        store(5'h01, 7'h30);
        store(5'h02, 7'h30);
        wr(`TPS_OFF_IRQ_MASK, 32'h80);
        pulse();
        ticks(1);
        pulse();
        chk_code("clamp", 15'sd3465, lp);
        rd(`TPS_OFF_IRQ_STAT, 32'h80);
        chk("ovf irq", 32'h1, {31'h0, irq});
        ticks(21);
        chk("ovf held", 32'h1, {31'h0, irq});
        wr(`TPS_OFF_IRQ_STAT, 32'h80);
        @(negedge clk_in);
        chk("irq clear", 32'h0, {31'h0, irq});
        // Over-current in limit mode, then edge choice and mask
        @(posedge clk_in);
        short <= 1;
        settle();
        settle();
        chk("limit", 32'h1, {31'h0, lim});
        rd(`TPS_OFF_LINE_COND, 32'h10);
        rd(`TPS_OFF_IRQ_STAT, 32'h10);
        chk("oc irq", 32'h1, {31'h0, irq});
        wr(`TPS_OFF_TMF_SEL, 32'h1);
        settle();
        chk("tmf", 32'h1, {31'h0, tmf});
        wr(`TPS_OFF_IRQ_STAT, 32'h10);
        rd(`TPS_OFF_IRQ_STAT, 32'h0);
        wr(`TPS_OFF_IRQ_EDGE, 32'h10);
        short <= 0;
        settle();
        settle();
        rd(`TPS_OFF_IRQ_STAT, 32'h10);
        wr(`TPS_OFF_IRQ_MASK, 32'h90);
        @(negedge clk_in);
        chk("oc masked", 32'h0, {31'h0, irq});
        wr(`TPS_OFF_TXCFG, 32'h50);
        short <= 1;
        settle();
        settle();
        chk("oc float", 32'h6, {29'h0, oep, oen, lim});
        wr(`TPS_OFF_TXCFG, 32'h00);
        @(negedge clk_in);
        chk("oe bit", 32'h3, {30'h0, oep, oen});
        conclude();
    end
endmodule
